// >>> shared/intc_edge_consts.svh
// Purpose: offsets, field positions, reset values and vector numbers
// Assumes: register offsets are word indexes; byte address = 4 * index
// Notes:   definitions only
`ifndef INTC_EDGE_CONSTS_SVH
`define INTC_EDGE_CONSTS_SVH

// ****************************************
// register indexes
// ****************************************
`define IDX_WAKEUP_EDGE_SELECT      16'hFF90
`define IDX_EXTERNAL_EDGE_SELECT    16'hFFF2
`define IDX_INTERRUPT_ENABLE_FIRST  16'hFFF3
`define IDX_INTERRUPT_ENABLE_SECOND 16'hFFF4
`define IDX_REQUEST_FLAGS_FIRST     16'hFFF6
`define IDX_REQUEST_FLAGS_SECOND    16'hFFF7
`define IDX_WAKEUP_REQUEST_FLAGS    16'hFFF9

// ****************************************
// reset values
// ****************************************
`define RST_WAKEUP_EDGE_SELECT      8'h00
`define RST_EXTERNAL_EDGE_SELECT    8'hE0
`define RST_INTERRUPT_ENABLE_FIRST  8'h00
`define RST_INTERRUPT_ENABLE_SECOND 8'h00
`define RST_REQUEST_FLAGS_FIRST     8'h20
`define RST_REQUEST_FLAGS_SECOND    8'h00
`define RST_WAKEUP_REQUEST_FLAGS    8'h00

// ****************************************
// fixed bits and field positions
// ****************************************
`define EDGE_SEL_FIXED_ONES         8'hE0
`define FLAGS_FIRST_FIXED_ONES      8'h20
`define BIT_TIMER_A                 7
`define BIT_SERIAL_ONE              6
`define BIT_WAKEUP_GROUP            5
`define BIT_DIRECT_TRANSFER         7
`define BIT_CONVERSION_END          6
`define BIT_SPARE                   5
`define BIT_TIMER_G                 4
`define BIT_TIMER_F_HIGH            3
`define BIT_TIMER_F_LOW             2
`define BIT_TIMER_C                 1
`define BIT_EVENT_COUNTER           0

// ****************************************
// vector numbers
// ****************************************
`define VEC_EXT_BASE                5'h04
`define VEC_WAKEUP                  5'h09
`define VEC_TIMER_A                 5'h0B
`define VEC_EVENT_COUNTER           5'h0C
`define VEC_TIMER_C                 5'h0D
`define VEC_TIMER_F_LOW             5'h0E
`define VEC_TIMER_F_HIGH            5'h0F
`define VEC_TIMER_G                 5'h10
`define VEC_CONVERSION_END          5'h13
`define VEC_DIRECT_TRANSFER         5'h14
`define VEC_COUNT                   21

`endif

// >>> shared/intc_edge_pkg.sv
// Purpose: types of the interrupt enable and edge control block
// Assumes: constants come from intc_edge_consts.svh
// Notes:   whole state of the block is one packed struct
package intc_edge_pkg;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} bus_phase_t;

	typedef struct packed {
		bus_phase_t  phase;
		logic        waitReq;
		logic [7:0]  readData;
		logic [4:0]  edgeSel;
		logic [7:0]  wakeEdge;
		logic [7:0]  enableFirst;
		logic [7:0]  enableSecond;
		logic [7:0]  flagsFirst;
		logic [7:0]  flagsSecond;
		logic [7:0]  wakeFlags;
		logic [15:0] pinPrev;
		logic        primed;
		logic        irqReq;
		logic [4:0]  irqVec;
		logic        convTrigEdge;
		logic        timerFEdge;
		logic        timerCEdge;
	} state_t;

endpackage

// >>> logic/intc_edge_ctrl.sv
// Purpose: edge sensing, enable gating and vectored request to the CPU
// Assumes: all inputs synchronous to clk; event inputs are 1-cycle pulses
// Notes:   registers reached over Avalon-MM, one wait cycle per access
`timescale 1ns/1ps
`include "intc_edge_consts.svh"

module intc_edge_ctrl (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [17:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic [4:0]  extRequestPin,
	input  wire logic [7:0]  wakeupPin,
	input  wire logic        converterTriggerPin,
	input  wire logic        timerFEventPin,
	input  wire logic        timerCEventPin,
	input  wire logic        timerAOvf,
	input  wire logic        serialOneDone,
	input  wire logic        wakeupReserved,
	input  wire logic        directTransfer,
	input  wire logic        conversionEnd,
	input  wire logic        timerGEvent,
	input  wire logic        timerFHighEvent,
	input  wire logic        timerFLowEvent,
	input  wire logic        timerCEvent,
	input  wire logic        eventCounterOvf,
	input  wire logic        globalMask,
	output logic             irqRequest,
	output logic      [4:0]  irqVector,
	output logic             converterTriggerEdge,
	output logic             timerFEdge,
	output logic             timerCEdge
);
	import intc_edge_pkg::*;

	// one-hot register select positions
	localparam int SEL_WAKE_EDGE = 0;
	localparam int SEL_EDGE      = 1;
	localparam int SEL_EN_FIRST  = 2;
	localparam int SEL_EN_SECOND = 3;
	localparam int SEL_FL_FIRST  = 4;
	localparam int SEL_FL_SECOND = 5;
	localparam int SEL_WAKE_FL   = 6;

	// ****************************************
	// functions
	// ****************************************

	// sel 1 senses a rising edge, sel 0 a falling one
	function automatic logic edgeHit(
		input logic prev,
		input logic cur,
		input logic sel
	);
		edgeHit = sel ? (!prev && cur) : (prev && !cur);
	endfunction

	// a write of 0 clears, a write of 1 keeps; a set in the same
	// cycle wins so no event is lost to a racing clear
	function automatic logic [7:0] flagUpdate(
		input logic [7:0] cur,
		input logic       wr,
		input logic [7:0] data,
		input logic [7:0] set
	);
		logic [7:0] clr;
		clr = wr ? ~data : 8'h00;
		flagUpdate = (cur & ~clr) | set;
	endfunction

	// lowest vector number is the highest priority
	function automatic logic [4:0] pickVector(
		input logic [`VEC_COUNT-1:0] pend
	);
		logic [4:0] v;
		v = 5'h00;
		for (int i = `VEC_COUNT - 1; i >= 0; i--) begin
			if (pend[i]) begin
				v = 5'(i);
			end
		end
		pickVector = v;
	endfunction

	// word index to one-hot select, zero where nothing is mapped;
	// read mux and write strobes share it so they cannot disagree
	function automatic logic [6:0] decodeReg(
		input logic [15:0] idx
	);
		logic [6:0] sel;
		sel = 7'h00;
		if (idx == `IDX_WAKEUP_EDGE_SELECT) begin
			sel[SEL_WAKE_EDGE] = 1'b1;
		end else if (idx == `IDX_EXTERNAL_EDGE_SELECT) begin
			sel[SEL_EDGE] = 1'b1;
		end else if (idx == `IDX_INTERRUPT_ENABLE_FIRST) begin
			sel[SEL_EN_FIRST] = 1'b1;
		end else if (idx == `IDX_INTERRUPT_ENABLE_SECOND) begin
			sel[SEL_EN_SECOND] = 1'b1;
		end else if (idx == `IDX_REQUEST_FLAGS_FIRST) begin
			sel[SEL_FL_FIRST] = 1'b1;
		end else if (idx == `IDX_REQUEST_FLAGS_SECOND) begin
			sel[SEL_FL_SECOND] = 1'b1;
		end else if (idx == `IDX_WAKEUP_REQUEST_FLAGS) begin
			sel[SEL_WAKE_FL] = 1'b1;
		end
		decodeReg = sel;
	endfunction

	// ****************************************
	// state
	// ****************************************
	state_t state_reg;
	state_t state_next;

	logic        access;
	logic        wrLow;
	logic [15:0] regIdx;
	logic [6:0]  regSel;
	logic [7:0]  wrByte;
	logic [7:0]  readValue;
	logic [15:0] pinNow;
	logic [15:0] pinSel;
	logic [15:0] hits;
	logic [7:0]  setFirst;
	logic [7:0]  setSecond;
	logic [7:0]  setWake;
	logic        wakeAny;
	logic [`VEC_COUNT-1:0] pending;

	assign regIdx = address[17:2];
	assign regSel = decodeReg(regIdx);
	assign wrByte = writedata[7:0];
	// an access takes effect on the edge where waitrequest is low
	assign access = (read || write) && !state_reg.waitReq;
	assign wrLow  = write && access && byteenable[0];

	// ****************************************
	// edge sensing
	// ****************************************

	// sample order: ext pins 4..0, converter, timer F, timer C, wakeups
	assign pinNow = {wakeupPin, timerCEventPin, timerFEventPin,
		converterTriggerPin, extRequestPin};
	assign pinSel = {state_reg.wakeEdge,
		state_reg.edgeSel[1],
		state_reg.edgeSel[3],
		state_reg.edgeSel[4],
		state_reg.edgeSel};

	always_comb begin
		hits = 16'h0000;
		// first cycle after reset only learns the levels, since a pin
		// held high would otherwise look like a rising edge
		if (state_reg.primed) begin
			for (int i = 0; i < 16; i++) begin
				hits[i] = edgeHit(state_reg.pinPrev[i], pinNow[i],
					pinSel[i]);
			end
		end
	end

	// ****************************************
	// flag set sources
	// ****************************************
	always_comb begin
		setFirst = 8'h00;
		setFirst[`BIT_TIMER_A] = timerAOvf;
		setFirst[`BIT_SERIAL_ONE] = serialOneDone;
		setFirst[4:0] = hits[4:0];
		setSecond = 8'h00;
		setSecond[`BIT_DIRECT_TRANSFER] = directTransfer;
		setSecond[`BIT_CONVERSION_END] = conversionEnd;
		setSecond[`BIT_TIMER_G] = timerGEvent;
		setSecond[`BIT_TIMER_F_HIGH] = timerFHighEvent;
		setSecond[`BIT_TIMER_F_LOW] = timerFLowEvent;
		setSecond[`BIT_TIMER_C] = timerCEvent;
		setSecond[`BIT_EVENT_COUNTER] = eventCounterOvf;
		setWake = hits[15:8];
	end

	// ****************************************
	// pending requests by vector number
	// ****************************************
	always_comb begin
		pending = '0;
		wakeAny = |state_reg.wakeFlags;
		for (int n = 0; n < 5; n++) begin
			pending[`VEC_EXT_BASE + n] = state_reg.flagsFirst[n] &&
				state_reg.enableFirst[n];
		end
		pending[`VEC_WAKEUP] = wakeAny &&
			state_reg.enableFirst[`BIT_WAKEUP_GROUP];
		pending[`VEC_TIMER_A] = state_reg.flagsFirst[`BIT_TIMER_A] &&
			state_reg.enableFirst[`BIT_TIMER_A];
		pending[`VEC_EVENT_COUNTER] =
			state_reg.flagsSecond[`BIT_EVENT_COUNTER] &&
			state_reg.enableSecond[`BIT_EVENT_COUNTER];
		pending[`VEC_TIMER_C] = state_reg.flagsSecond[`BIT_TIMER_C] &&
			state_reg.enableSecond[`BIT_TIMER_C];
		pending[`VEC_TIMER_F_LOW] =
			state_reg.flagsSecond[`BIT_TIMER_F_LOW] &&
			state_reg.enableSecond[`BIT_TIMER_F_LOW];
		pending[`VEC_TIMER_F_HIGH] =
			state_reg.flagsSecond[`BIT_TIMER_F_HIGH] &&
			state_reg.enableSecond[`BIT_TIMER_F_HIGH];
		pending[`VEC_TIMER_G] = state_reg.flagsSecond[`BIT_TIMER_G] &&
			state_reg.enableSecond[`BIT_TIMER_G];
		pending[`VEC_CONVERSION_END] =
			state_reg.flagsSecond[`BIT_CONVERSION_END] &&
			state_reg.enableSecond[`BIT_CONVERSION_END];
		pending[`VEC_DIRECT_TRANSFER] =
			state_reg.flagsSecond[`BIT_DIRECT_TRANSFER] &&
			state_reg.enableSecond[`BIT_DIRECT_TRANSFER];
		// slots 0..3 and 10 stay empty; the serial done flag and its
		// enable exist but own no vector slot
		pending[3:0] = 4'h0;
		pending[10] = 1'b0;
	end

	// ****************************************
	// register read mux
	// ****************************************
	always_comb begin
		readValue = 8'h00;
		if (regSel[SEL_WAKE_EDGE]) begin
			readValue = state_reg.wakeEdge;
		end else if (regSel[SEL_EDGE]) begin
			readValue = `EDGE_SEL_FIXED_ONES |
				{3'h0, state_reg.edgeSel};
		end else if (regSel[SEL_EN_FIRST]) begin
			readValue = state_reg.enableFirst;
		end else if (regSel[SEL_EN_SECOND]) begin
			readValue = state_reg.enableSecond;
		end else if (regSel[SEL_FL_FIRST]) begin
			readValue = state_reg.flagsFirst | `FLAGS_FIRST_FIXED_ONES;
		end else if (regSel[SEL_FL_SECOND]) begin
			readValue = state_reg.flagsSecond;
		end else if (regSel[SEL_WAKE_FL]) begin
			readValue = state_reg.wakeFlags;
		end
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		state_next = state_reg;
		state_next.pinPrev = pinNow;
		state_next.primed = 1'b1;
		state_next.convTrigEdge = hits[5];
		state_next.timerFEdge = hits[6];
		state_next.timerCEdge = hits[7];

		// bus handshake: one wait cycle, then one cycle with
		// waitrequest low where the access is taken
		case (state_reg.phase)
			BUS_IDLE: begin
				if (read || write) begin
					state_next.phase = BUS_ACK;
					state_next.waitReq = 1'b0;
					state_next.readData = readValue;
				end
			end
			BUS_ACK: begin
				state_next.phase = BUS_IDLE;
				state_next.waitReq = 1'b1;
			end
			default: begin
				state_next.phase = BUS_IDLE;
				state_next.waitReq = 1'b1;
			end
		endcase

		// plain control registers
		if (wrLow) begin
			if (regSel[SEL_WAKE_EDGE]) begin
				state_next.wakeEdge = wrByte;
			end else if (regSel[SEL_EDGE]) begin
				state_next.edgeSel = wrByte[4:0];
			end else if (regSel[SEL_EN_FIRST]) begin
				state_next.enableFirst = wrByte;
			end else if (regSel[SEL_EN_SECOND]) begin
				state_next.enableSecond = wrByte;
			end
		end

		// flags: hardware sets always, mask or not
		state_next.flagsFirst = flagUpdate(state_reg.flagsFirst,
			wrLow && regSel[SEL_FL_FIRST],
			wrByte, setFirst);
		state_next.flagsFirst[`BIT_WAKEUP_GROUP] = 1'b0;
		state_next.flagsSecond = flagUpdate(state_reg.flagsSecond,
			wrLow && regSel[SEL_FL_SECOND],
			wrByte, setSecond);
		// spare bit of the second flag register is plain storage
		if (wrLow && regSel[SEL_FL_SECOND]) begin
			state_next.flagsSecond[`BIT_SPARE] = wrByte[`BIT_SPARE];
		end
		state_next.wakeFlags = flagUpdate(state_reg.wakeFlags,
			wrLow && regSel[SEL_WAKE_FL],
			wrByte, setWake);

		// request to the CPU; accepting it changes no flag
		state_next.irqReq = (|pending) && !globalMask;
		state_next.irqVec = (|pending) && !globalMask ?
			pickVector(pending) : 5'h00;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg.phase <= BUS_IDLE;
			state_reg.waitReq <= 1'b1;
			state_reg.readData <= 8'h00;
			state_reg.edgeSel <= 5'h00;
			state_reg.wakeEdge <= `RST_WAKEUP_EDGE_SELECT;
			state_reg.enableFirst <= `RST_INTERRUPT_ENABLE_FIRST;
			state_reg.enableSecond <= `RST_INTERRUPT_ENABLE_SECOND;
			state_reg.flagsFirst <= 8'h00;
			state_reg.flagsSecond <= `RST_REQUEST_FLAGS_SECOND;
			state_reg.wakeFlags <= `RST_WAKEUP_REQUEST_FLAGS;
			state_reg.pinPrev <= 16'h0000;
			state_reg.primed <= 1'b0;
			state_reg.irqReq <= 1'b0;
			state_reg.irqVec <= 5'h00;
			state_reg.convTrigEdge <= 1'b0;
			state_reg.timerFEdge <= 1'b0;
			state_reg.timerCEdge <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// outputs, all from flip-flops
	// ****************************************
	assign readdata = {24'h000000, state_reg.readData};
	assign waitrequest = state_reg.waitReq;
	assign irqRequest = state_reg.irqReq;
	assign irqVector = state_reg.irqVec;
	assign converterTriggerEdge = state_reg.convTrigEdge;
	assign timerFEdge = state_reg.timerFEdge;
	assign timerCEdge = state_reg.timerCEdge;

endmodule

// >>> testbench/intc_edge_ctrl_asserts.sv
// Purpose: port level checks of intc_edge_ctrl
// Assumes: one clock, synchronous active low reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ps

module intc_edge_ctrl_asserts (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest,
	input  wire logic        globalMask,
	input  wire logic        irqRequest,
	input  wire logic [4:0]  irqVector,
	input  wire logic        converterTriggerEdge,
	input  wire logic        timerFEdge,
	input  wire logic        timerCEdge
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// ****************************************
	// checks
	// ****************************************
	property p_maskBlocks;
		globalMask |=> !irqRequest;
	endproperty
	a_maskBlocks: assert property (p_maskBlocks)
		else $error("request shown while masked");
	property p_noReserved;
		irqRequest |-> !(irqVector inside {[5'h00:5'h03], 5'h0A});
	endproperty
	a_noReserved: assert property (p_noReserved)
		else $error("reserved vector presented");
	// write excluded: a cleared flag drops the request one edge late
	property p_flagHolds;
		irqRequest && !globalMask && !write && !$past(write) |=> irqRequest;
	endproperty
	a_flagHolds: assert property (p_flagHolds)
		else $error("request dropped without a clear");
	property p_waitOne;
		!waitrequest |=> waitrequest;
	endproperty
	a_waitOne: assert property (p_waitOne)
		else $error("waitrequest low for more than one cycle");
	property p_answer;
		(read || write) && waitrequest |=> !waitrequest;
	endproperty
	a_answer: assert property (p_answer)
		else $error("access not answered in one cycle");
	property p_readUpper;
		read && !waitrequest |-> readdata[31:8] == 24'h000000;
	endproperty
	a_readUpper: assert property (p_readUpper)
		else $error("upper read data not zero");
	property p_convPulse;
		converterTriggerEdge |=> !converterTriggerEdge;
	endproperty
	a_convPulse: assert property (p_convPulse)
		else $error("converter edge pulse too long");
	property p_timerFPulse;
		timerFEdge |=> !timerFEdge;
	endproperty
	a_timerFPulse: assert property (p_timerFPulse)
		else $error("timer F edge pulse too long");
	property p_timerCPulse;
		timerCEdge |=> !timerCEdge;
	endproperty
	a_timerCPulse: assert property (p_timerCPulse)
		else $error("timer C edge pulse too long");
endmodule

bind intc_edge_ctrl intc_edge_ctrl_asserts chk (
	.clk(clk), .resetn(resetn), .read(read), .write(write),
	.readdata(readdata), .waitrequest(waitrequest),
	.globalMask(globalMask), .irqRequest(irqRequest),
	.irqVector(irqVector), .converterTriggerEdge(converterTriggerEdge),
	.timerFEdge(timerFEdge), .timerCEdge(timerCEdge)
);

// >>> testbench/cpu_core_model.sv
// Purpose: behavioural CPU core taking vectored requests
// Assumes: mask bit comes from the bench
// Notes:   records the last vector it accepted
`timescale 1ns/1ps

module cpu_core_model (
	input  wire logic       clk,
	input  wire logic       maskBit,
	input  wire logic       irqRequest,
	input  wire logic [4:0] irqVector,
	output logic            globalMask,
	output logic      [4:0] takenVector
);
	// ****************************************
	// acceptance
	// ****************************************
	assign globalMask = maskBit;
	// acceptance never writes flags; software must clear them
	always_ff @(posedge clk) begin
		if (irqRequest && !globalMask) begin
			takenVector <= irqVector;
		end
	end
endmodule

// >>> testbench/testbench.sv
// Purpose: register and request tests of intc_edge_ctrl
// Assumes: byte address is four times the register index
// Notes:   fixed waits follow the one-edge latencies of the block
`timescale 1ns/1ps
`include "intc_edge_consts.svh"

module testbench;
	localparam logic [15:0] aEdge = `IDX_EXTERNAL_EDGE_SELECT;
	localparam logic [15:0] aEn1 = `IDX_INTERRUPT_ENABLE_FIRST;
	localparam logic [15:0] aEn2 = `IDX_INTERRUPT_ENABLE_SECOND;
	localparam logic [15:0] aFl1 = `IDX_REQUEST_FLAGS_FIRST;
	localparam logic [15:0] aFl2 = `IDX_REQUEST_FLAGS_SECOND;
	localparam logic [15:0] aWk = `IDX_WAKEUP_REQUEST_FLAGS;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [17:0] address = '0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = '0;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [4:0]  pins = 5'h1F;
	logic [7:0]  wake = 8'hFF;
	logic [2:0]  tpins = 3'b111;
	logic [8:0]  ev = '0;
	logic        maskBit = 1'b0;
	logic        globalMask;
	logic        irqRequest;
	logic [4:0]  irqVector;
	logic [4:0]  taken;
	logic [2:0]  edges;
	logic [1:0]  nE [3] = '{2'd0, 2'd0, 2'd0};
	int          n_mismatch = 0;
	int          checked = 0;
	logic [15:0] idxT [7] = '{16'hFF90, aEdge, aEn1, aEn2, aFl1, aFl2, aWk};
	logic [7:0]  rstT [7] = '{8'h00, 8'hE0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
	logic [2:0]  bitT [9] = '{3'd7, 3'd6, 3'd7, 3'd6, 3'd4, 3'd3, 3'd2,
		3'd1, 3'd0};
	logic [4:0]  vecT [9] = '{5'h0B, 5'h00, 5'h14, 5'h13, 5'h10, 5'h0F, 5'h0E,
		5'h0D, 5'h0C};
	logic [7:0]  m;

	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		for (int j = 0; j < 3; j++) begin
			if (edges[j] === 1'b1) nE[j]++;
		end
	end

	intc_edge_ctrl dut (
		.clk(clk), .resetn(resetn), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.extRequestPin(pins), .wakeupPin(wake),
		.converterTriggerPin(tpins[2]), .timerFEventPin(tpins[1]),
		.timerCEventPin(tpins[0]), .timerAOvf(ev[0]),
		.serialOneDone(ev[1]), .wakeupReserved(1'b0),
		.directTransfer(ev[2]), .conversionEnd(ev[3]),
		.timerGEvent(ev[4]), .timerFHighEvent(ev[5]),
		.timerFLowEvent(ev[6]), .timerCEvent(ev[7]),
		.eventCounterOvf(ev[8]), .globalMask(globalMask),
		.irqRequest(irqRequest), .irqVector(irqVector),
		.converterTriggerEdge(edges[2]), .timerFEdge(edges[1]),
		.timerCEdge(edges[0])
	);
	cpu_core_model cpu (
		.clk(clk), .maskBit(maskBit), .irqRequest(irqRequest),
		.irqVector(irqVector), .globalMask(globalMask), .takenVector(taken)
	);

	// ****************************************
	// tasks
	// ****************************************
	task automatic wrap_up();
		if (n_mismatch == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkIrq(input logic r, input logic [4:0] v);
		checked++;
		if (irqRequest !== r || (r && irqVector !== v)) begin
			n_mismatch++;
			$display("ERROR %0t request %b vector %h", $time, irqRequest,
				irqVector);
		end
	endtask
	task automatic bus(input logic [15:0] idx, input logic w,
		input logic [7:0] d, input logic be, output logic [7:0] q);
		int i;
		@(posedge clk);
		address <= {idx, 2'b00};
		read <= !w;
		write <= w;
		writedata <= {24'h000000, d};
		byteenable <= {3'b000, be};
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) break;
		end
		if (i == 20) begin
			n_mismatch++;
			$display("ERROR %0t bus access timed out", $time);
			wrap_up();
		end
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(idx, 1'b1, d, 1'b1, q);
	endtask
	task automatic rdChk(input logic [15:0] idx, input logic [7:0] e);
		logic [7:0] q;
		bus(idx, 1'b0, 8'h00, 1'b1, q);
		chk8(q, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial begin
		tick(8);
		resetn <= 1'b1;
		tick(2);
		for (int k = 0; k < 7; k++) rdChk(idxT[k], rstT[k]);
		rdChk(16'h0000, 8'h00);
		wr(aEdge, 8'h00);
		rdChk(aEdge, 8'hE0);
		wr(aEn2, 8'h20);
		rdChk(aEn2, 8'h20);
		wr(aEn1, 8'hA5);
		wr(16'h0000, 8'h5A);
		bus(aEn1, 1'b1, 8'hFF, 1'b0, m);
		rdChk(aEn1, 8'hA5);
		wr(aEn1, 8'h00);
		wr(aEn2, 8'h00);
		// idle level is set first so only the chosen edge is counted
		for (int n = 0; n < 5; n++) begin
			for (int e = 0; e < 2; e++) begin
				m = 8'h01 << n;
				wr(aEdge, e ? m : 8'h00);
				pins <= e ? 5'h1F ^ m[4:0] : 5'h1F;
				tick(3);
				wr(aFl1, 8'h00);
				wr(aEn1, m);
				pins <= pins ^ m[4:0];
				tick(3);
				chkIrq(1'b1, 5'h04 + 5'(n));
				pins <= pins ^ m[4:0];
				tick(3);
				wr(aFl1, 8'hFF);
				rdChk(aFl1, 8'h20 | m);
				wr(aEn1, 8'h00);
				tick(2);
				chkIrq(1'b0, 5'h00);
				wr(aFl1, 8'hFF ^ m);
				rdChk(aFl1, 8'h20);
			end
		end
		wr(aEdge, 8'h00);
		pins <= 5'h1F;
		tick(3);
		wr(aFl1, 8'h00);
		wr(aEn1, 8'h1F);
		pins <= 5'h15;
		tick(3);
		chkIrq(1'b1, 5'h05);
		maskBit <= 1'b1;
		tick(3);
		chkIrq(1'b0, 5'h00);
		rdChk(aFl1, 8'h2A);
		maskBit <= 1'b0;
		tick(4);
		chk8({3'b000, taken}, 8'h05);
		rdChk(aFl1, 8'h2A);
		wr(aFl1, 8'hFD);
		tick(2);
		chkIrq(1'b1, 5'h07);
		wr(aFl1, 8'h00);
		wr(aEn1, 8'h00);
		for (int k = 0; k < 9; k++) begin
			m = 8'h01 << bitT[k];
			@(posedge clk);
			ev <= 9'h001 << k;
			@(posedge clk);
			ev <= '0;
			tick(2);
			chkIrq(1'b0, 5'h00);
			rdChk(k < 2 ? aFl1 : aFl2, (k < 2 ? 8'h20 : 8'h00) | m);
			wr(k < 2 ? aEn1 : aEn2, m);
			tick(2);
			chkIrq(vecT[k] != 5'h00, vecT[k]);
			wr(k < 2 ? aFl1 : aFl2, 8'h00);
			wr(k < 2 ? aEn1 : aEn2, 8'h00);
		end
		wr(aEn1, 8'h20);
		wake <= 8'h7F;
		tick(3);
		chkIrq(1'b1, 5'h09);
		rdChk(aWk, 8'h80);
		wr(aWk, 8'h00);
		wake <= 8'hFF;
		tick(3);
		chkIrq(1'b0, 5'h00);
		wr(aEdge, 8'h1A);
		tpins <= 3'b000;
		tick(3);
		tpins <= 3'b111;
		tick(3);
		chk8({2'b00, nE[2], nE[1], nE[0]}, 8'h15);
		wr(aEdge, 8'h00);
		tpins <= 3'b000;
		tick(3);
		chk8({2'b00, nE[2], nE[1], nE[0]}, 8'h2A);
		wrap_up();
	end
endmodule
